// File: bep_host.sv
`timescale 1ns/10ps
module bep_host
  import bep_pkg::*;
#(
  parameter int PROG_TIMEOUT_CYC = BEP_PROG_TIMEOUT_CYC,
  parameter bit SELECT_CONTROLLED = 1'b0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [BEP_ADDR_W-1:0] req_addr,
  input wire logic [BEP_DATA_W-1:0] req_wdata,
  output logic rsp_valid,
  output logic [BEP_DATA_W-1:0] rsp_rdata,
  output logic rsp_timeout,
  output logic [BEP_ADDR_W-1:0] address_inputs,
  output logic [BEP_DATA_W-1:0] data_lines_out,
  output logic data_lines_oe_n,
  input wire logic [BEP_DATA_W-1:0] data_lines_in,
  output logic chip_select_n,
  output logic output_enable_n,
  output logic write_strobe_n,
  input wire logic ready_busy
);
  // refuse a timeout that would expire before busy can even be seen
  if (PROG_TIMEOUT_CYC < BEP_BUSY_WAIT_CYC + 1) begin : g_bad_timeout
    $error("timeout too short");
  end

  typedef enum logic [2:0] {
    BEP_IDLE, BEP_SETUP, BEP_READ, BEP_STROBE, BEP_HOLD, BEP_BUSYWAIT, BEP_PROG
  } bep_state_t;

  bep_state_t state_reg;
  logic [31:0] cnt_reg;
  logic write_reg;
  logic [BEP_DATA_W-1:0] rd_sync1_reg, rd_sync2_reg;
  logic rb_sync1_reg, rb_sync2_reg;

  // two-stage sync on pins; data only settles after the access time anyway
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_sync1_reg <= '0;
      rd_sync2_reg <= '0;
      rb_sync1_reg <= 1'b1;
      rb_sync2_reg <= 1'b1;
    end else begin
      rd_sync1_reg <= data_lines_in;
      rd_sync2_reg <= rd_sync1_reg;
      rb_sync1_reg <= ready_busy;
      rb_sync2_reg <= rb_sync1_reg;
    end
  end

  // accept only when idle and the device reports ready
  assign req_ready = (state_reg == BEP_IDLE) && rb_sync2_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= BEP_IDLE;
      cnt_reg <= '0;
      write_reg <= 1'b0;
      address_inputs <= '0;
      data_lines_out <= '0;
      data_lines_oe_n <= 1'b1;
      chip_select_n <= 1'b1;
      output_enable_n <= 1'b1;
      write_strobe_n <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      rsp_timeout <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      rsp_timeout <= 1'b0;
      unique case (state_reg)
        BEP_IDLE: begin
          chip_select_n <= 1'b1; // deselected: device floats its lines
          output_enable_n <= 1'b1;
          write_strobe_n <= 1'b1;
          data_lines_oe_n <= 1'b1;
          if (req_valid && req_ready) begin
            address_inputs <= req_addr; // address first
            write_reg <= req_write;
            cnt_reg <= 32'(BEP_SETUP_CYC);
            if (req_write) begin
              data_lines_out <= req_wdata;
              data_lines_oe_n <= 1'b0;
              if (SELECT_CONTROLLED) write_strobe_n <= 1'b0; // strobe before select
            end
            state_reg <= BEP_SETUP;
          end
        end
        BEP_SETUP: begin
          if (cnt_reg <= 32'd1) begin
            chip_select_n <= 1'b0;
            if (write_reg) begin
              // hv erase modes not driven: logic pins cannot reach 20 V
              write_strobe_n <= 1'b0;
              cnt_reg <= 32'(BEP_WP_CYC);
              state_reg <= BEP_STROBE;
            end else begin
              output_enable_n <= 1'b0;
              cnt_reg <= 32'(BEP_ACCESS_CYC + 2);
              state_reg <= BEP_READ;
            end
          end else cnt_reg <= cnt_reg - 32'd1;
        end
        BEP_READ: begin
          // address held throughout; sample after access time plus sync
          if (cnt_reg <= 32'd1) begin
            rsp_rdata <= rd_sync2_reg;
            rsp_valid <= 1'b1;
            output_enable_n <= 1'b1;
            chip_select_n <= 1'b1;
            state_reg <= BEP_IDLE;
          end else cnt_reg <= cnt_reg - 32'd1;
        end
        BEP_STROBE: begin
          if (cnt_reg <= 32'd1) begin
            // end of pulse latches data in the device
            if (SELECT_CONTROLLED) chip_select_n <= 1'b1;
            else write_strobe_n <= 1'b1;
            cnt_reg <= 32'(BEP_DH_CYC);
            state_reg <= BEP_HOLD;
          end else cnt_reg <= cnt_reg - 32'd1;
        end
        BEP_HOLD: begin
          if (cnt_reg <= 32'd1) begin
            // device holds the latched word, bus released
            chip_select_n <= 1'b1;
            write_strobe_n <= 1'b1;
            data_lines_oe_n <= 1'b1;
            cnt_reg <= 32'(BEP_BUSY_WAIT_CYC);
            state_reg <= BEP_BUSYWAIT;
          end else cnt_reg <= cnt_reg - 32'd1;
        end
        BEP_BUSYWAIT: begin
          // busy must not be trusted before its assert delay
          if (cnt_reg <= 32'd1) begin
            cnt_reg <= 32'(PROG_TIMEOUT_CYC);
            state_reg <= BEP_PROG;
          end else cnt_reg <= cnt_reg - 32'd1;
        end
        BEP_PROG: begin
          // wait for ready; bounded so a dead part cannot hang the host
          if (rb_sync2_reg) begin
            rsp_valid <= 1'b1;
            state_reg <= BEP_IDLE;
          end else if (cnt_reg <= 32'd1) begin
            rsp_valid <= 1'b1;
            rsp_timeout <= 1'b1;
            state_reg <= BEP_IDLE;
          end else cnt_reg <= cnt_reg - 32'd1;
        end
      endcase
    end
  end
endmodule : bep_host

// File: bep_pkg.sv
// Behaviour
// - host holds address stable through read
// - address first, then select, then output enable (code lowers select and output enable on the same edge); host drops select and output enable on the same edge
// - host may tie output enable low
// - select low, stable address/data, pulse write strobe
// - select-controlled: write strobe low before select
// - high-voltage erase modes are optional
// - host waits for ready before next access
package bep_pkg;
  localparam int BEP_CLK_NS = 10;
  localparam int BEP_ADDR_W = 8;
  localparam int BEP_DATA_W = 8;
  // read access, strobe and busy timing in ns; program time in ms
  localparam int BEP_T_ACCESS_NS = 300;
  localparam int BEP_T_ADDR_SETUP_NS = 10;
  localparam int BEP_T_WP_NS = 150;
  localparam int BEP_T_DH_NS = 10;
  localparam int BEP_T_BUSY_ASSERT_DELAY_NS = 100;
  localparam int BEP_T_PROG_MAX_MS = 40;
  // least times round up
  localparam int BEP_ACCESS_CYC = (BEP_T_ACCESS_NS + BEP_CLK_NS - 1) / BEP_CLK_NS;
  localparam int BEP_SETUP_CYC = (BEP_T_ADDR_SETUP_NS + BEP_CLK_NS - 1) / BEP_CLK_NS;
  localparam int BEP_WP_CYC = (BEP_T_WP_NS + BEP_CLK_NS - 1) / BEP_CLK_NS;
  localparam int BEP_DH_CYC = (BEP_T_DH_NS + BEP_CLK_NS - 1) / BEP_CLK_NS;
  localparam int BEP_BUSY_WAIT_CYC =
    (BEP_T_BUSY_ASSERT_DELAY_NS + BEP_CLK_NS - 1) / BEP_CLK_NS + 2;
  localparam int BEP_PROG_TIMEOUT_CYC = BEP_T_PROG_MAX_MS * 1000000 / BEP_CLK_NS * 2;
  localparam logic [7:0] BEP_CNT_RESET = 8'h00;
endpackage : bep_pkg

// File: bep_host_assertions.sv
`timescale 1ns/10ps
module bep_host_chk (
  input logic clk,
  input logic nrst,
  input logic req_ready,
  input logic [7:0] address_inputs,
  input logic [7:0] data_lines_out,
  input logic data_lines_oe_n,
  input logic chip_select_n,
  input logic output_enable_n,
  input logic write_strobe_n,
  input logic ready_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_addr_held: assert property (!chip_select_n && !$past(chip_select_n) |->
    $stable(address_inputs)) else $error("addr moved");
  a_addr_first: assert property ($fell(chip_select_n) |-> $stable(address_inputs))
    else $error("select before addr");
  a_oe_in_sel: assert property (!output_enable_n |-> !chip_select_n && data_lines_oe_n)
    else $error("stray read");
  a_read_span: assert property ($fell(output_enable_n) |-> ##30 !output_enable_n)
    else $error("read short");
  a_wr_data: assert property (!write_strobe_n && !chip_select_n |->
    !data_lines_oe_n && output_enable_n && $stable(data_lines_out)) else $error("write data");
  a_wr_pulse: assert property ($fell(write_strobe_n) |-> ##14 !write_strobe_n)
    else $error("strobe short");
  a_busy_block: assert property ($past(ready_busy, 2) == 1'b0 |-> !req_ready)
    else $error("ready while busy");
  a_busy_nosel: assert property ($fell(chip_select_n) |-> $past(ready_busy, 3))
    else $error("select while busy");
endmodule : bep_host_chk
bind bep_host bep_host_chk i_chk (.clk, .nrst, .req_ready, .address_inputs, .data_lines_out,
  .data_lines_oe_n, .chip_select_n, .output_enable_n, .write_strobe_n, .ready_busy);

// File: bep_dev_model.sv
`timescale 1ns/10ps
module bep_dev_model
  import bep_pkg::*;
#(
  parameter int PROG_NS = 1000
) (
  input logic [7:0] address_inputs,
  input logic [7:0] data_lines_out,
  input logic data_lines_oe_n,
  input logic chip_select_n,
  input logic output_enable_n,
  input logic write_strobe_n,
  output logic [7:0] data_lines_in,
  output logic ready_busy
);
  logic [7:0] mem [256];
  logic [7:0] adr_q;
  logic [7:0] rd_q;
  logic rd_ok;
  logic pend = 1'b0;
  initial ready_busy = 1'b1;
  always @(negedge write_strobe_n) if (!chip_select_n) adr_q = address_inputs;
  // select-controlled: strobe already low when select falls
  always @(negedge chip_select_n) if (!write_strobe_n) adr_q = address_inputs;
  always @(posedge chip_select_n) if (!write_strobe_n && ready_busy) begin
    mem[adr_q] = data_lines_out;
    pend = 1'b1;
  end
  // busy delay always runs from the strobe rise, in both modes
  always @(posedge write_strobe_n) begin
    if (!chip_select_n && ready_busy) begin
      mem[adr_q] = data_lines_out;
      pend = 1'b1;
    end
    if (pend) begin
      pend = 1'b0;
      #(BEP_T_BUSY_ASSERT_DELAY_NS) ready_busy = 1'b0;
      #(PROG_NS) ready_busy = 1'b1;
    end
  end
  // worst-case access, so a host sampling early reads garbage
  assign #(BEP_T_ACCESS_NS) rd_ok = !chip_select_n && !output_enable_n && ready_busy;
  assign #(BEP_T_ACCESS_NS) rd_q = mem[address_inputs];
  // data needs select and output enable both low and ready, after the access time, so a host that ties output enable low reads only while selected
  always_comb begin
    if (!data_lines_oe_n) data_lines_in = data_lines_out;
    else if (rd_ok && !chip_select_n && !output_enable_n) data_lines_in = rd_q;
    else data_lines_in = ~rd_q;
  end
endmodule : bep_dev_model

// File: bep_host_tb.sv
`timescale 1ns/10ps
module bep_host_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [7:0] req_addr = 8'h00;
  logic [7:0] req_wdata = 8'h00;
  logic req_ready, rsp_valid, rsp_timeout, data_lines_oe_n, ready_busy;
  logic chip_select_n, output_enable_n, write_strobe_n;
  logic [7:0] rsp_rdata, address_inputs, data_lines_out, data_lines_in, rd;
  int bad_count = 0;
  int check_count = 0;
  always #5 clk = ~clk;
  bep_host #(.PROG_TIMEOUT_CYC(200)) i_dut (.clk, .nrst, .req_valid, .req_ready, .req_write,
    .req_addr, .req_wdata, .rsp_valid, .rsp_rdata, .rsp_timeout, .address_inputs,
    .data_lines_out, .data_lines_oe_n, .data_lines_in, .chip_select_n, .output_enable_n,
    .write_strobe_n, .ready_busy);
  bep_dev_model i_dev (.address_inputs, .data_lines_out, .data_lines_oe_n, .chip_select_n,
    .output_enable_n, .write_strobe_n, .data_lines_in, .ready_busy);
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, exp, seen);
    end
  endtask : chk
  // request held until the edge that samples ready; bounded waits throughout
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    do @(negedge clk); while (req_ready !== 1'b1 && ++n < 999);
    if (n >= 999) begin
      bad_count++;
      end_sim();
    end
    @(posedge clk);
    req_valid <= 1'b0;
    do @(negedge clk); while (rsp_valid !== 1'b1 && ++n < 2000);
    if (n >= 2000) begin
      bad_count++;
      end_sim();
    end
    rd = rsp_rdata;
    chk("timeout", {7'h00, rsp_timeout}, 8'h00);
  endtask : xfer
  task automatic t_fill_read;
    logic [7:0] ad [3] = '{8'h00, 8'h5A, 8'hFF};
    foreach (ad[i]) xfer(1'b1, ad[i], ad[i] ^ 8'h3C);
    foreach (ad[i]) begin
      xfer(1'b0, ad[i], 8'h00);
      chk("rdata", rd, ad[i] ^ 8'h3C);
    end
  endtask : t_fill_read
  task automatic t_rewrite;
    xfer(1'b1, 8'h81, 8'h11);
    xfer(1'b1, 8'h81, 8'hEE);
    xfer(1'b0, 8'h81, 8'h00);
    chk("rewrite", rd, 8'hEE);
  endtask : t_rewrite
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_fill_read();
    t_rewrite();
    end_sim();
  end
endmodule : bep_host_tb
